// ==== inc/spc_map.svh ====
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH

// Clock and timing
`define SPC_CLK_NS          10
`define SPC_CFG_PROG_NS     1000
`define SPC_EE_PROG_NS      4000
`define SPC_CFG_PROG_CYC    ((`SPC_CFG_PROG_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_EE_PROG_CYC     ((`SPC_EE_PROG_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

// Frame layout
`define SPC_CMD_BITS        4
`define SPC_PAY_BITS        16
`define SPC_OPER_BITS       8
`define SPC_WORD_BITS       20
`define SPC_FIFO_DEPTH      4

// Address map
`define SPC_CODE_BYTES      65536
`define SPC_EE_BYTES        256
`define SPC_ID_BASE         22'h200000
`define SPC_CFG_BASE        22'h300000
`define SPC_CFG_COUNT       14
`define SPC_CFG_LAST        4'hd
`define SPC_DEVID_LO        22'h3ffffe
`define SPC_DEVID_HI        22'h3fffff
`define SPC_ERASED          8'hff
`define SPC_UNIMPL          8'h00

// Implemented config bits, byte n at [8n+7:8n]; erased value equals this mask
`define SPC_CFG_MASK        112'h400fe00fc00f00c587001f1fcf3f
`define SPC_CFG_PROT_IDX    4'hb
`define SPC_CFG_PROT_BIT    5

// Internal register file addresses
`define SPC_F_PTR_U         8'hf8
`define SPC_F_PTR_H         8'hf7
`define SPC_F_PTR_L         8'hf6
`define SPC_F_LATCH         8'hf5
`define SPC_F_MEMCTL        8'ha6
`define SPC_F_EE_LO         8'ha9
`define SPC_F_EE_HI         8'haa
`define SPC_F_EE_DATA       8'ha8

// Control register bits
`define SPC_CTL_CODE_SEL    7
`define SPC_CTL_CFG_SEL     6
`define SPC_CTL_WREN        2
`define SPC_CTL_WR          1
`define SPC_CTL_RD          0

// Core instruction opcodes
`define SPC_OP_MOVLW        8'h0e
`define SPC_OP_MOVWF        8'h6e
`define SPC_OP_BSF          4'h8
`define SPC_OP_BCF          4'h9
`define SPC_OP_MOVF         6'h14

`endif

// ==== inc/spc_pkg.sv ====
package spc_pkg;

    typedef enum logic [3:0] {
        SPC_CMD_CORE  = 4'h0,
        SPC_CMD_SHOUT = 4'h2,
        SPC_CMD_TABLE_READ_OP = 4'h9,
        SPC_CMD_CFGWR = 4'hf
    } spc_cmd_t;

    typedef enum logic [1:0] {
        SPC_SH_CMD  = 2'b00,
        SPC_SH_PAY  = 2'b01,
        SPC_SH_OPER = 2'b10,
        SPC_SH_OUT  = 2'b11
    } spc_shift_t;

endpackage

// ==== inc/spc_stream_if.sv ====
`timescale 1ns/1ns
interface spc_stream_if #(
    parameter int W = 20
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/spc_pin_sync.sv ====
`timescale 1ns/1ns
module spc_pin_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pins
    input  wire logic ser_clk_i,
    input  wire logic ser_line_i,
    // Synchronised view
    output logic      clk_fall_o,
    output logic      line_o
);
    logic [2:0] clk_q;
    logic [1:0] line_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_q  <= 3'h0;
            line_q <= 2'h0;
        end else begin
            clk_q  <= {clk_q[1:0], ser_clk_i};
            line_q <= {line_q[0], ser_line_i};
        end
    end

    // Edge found between second and third stages only
    assign clk_fall_o = clk_q[2] & ~clk_q[1];
    assign line_o     = line_q[1];
endmodule

// ==== rtl/spc_fifo.sv ====
`timescale 1ns/1ns
module spc_fifo #(
    parameter int W     = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Streams
    spc_stream_if.snk  in_s,
    spc_stream_if.src  out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty = (wr_q == rd_q);
    wire          push  = in_s.valid & ~full;
    wire          pop   = out_s.ready & ~empty;

    assign in_s.ready  = ~full;
    assign out_s.valid = ~empty;
    assign out_s.data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + {{AW{1'b0}}, push};
            rd_q <= rd_q + {{AW{1'b0}}, pop};
        end
    end
endmodule

// ==== rtl/spc_prog_port.sv ====
// Notes on behaviour
// R1: Boot block is written by the normal code sequence within 000000h..0007FFh.
// R2: Each configuration write-and-start command programs exactly one byte.
// R3: Even pointer takes payload low byte, odd pointer takes high byte.
// R4: Programmer reloads the pointer before each configuration byte; no increment.
// R5: Programmer sets code and configuration select bits before configuration writes.
// R6: Write completes during the following no-operation command's clock high and low times.
// R7: Configuration writes are refused once the write-protect bit reads zero.
// R8: Table read returns the pointed byte serially, then increments the pointer.
// R9: Command shifted in LSB first; eight operand clocks, then eight output clocks.
// R10: Line turns to output after the eighth operand falling edge; clock held low.
// R11: Table reads work anywhere in the 22-bit space, including ID and config.
// R12: Post-increment from the last code address wraps the pointer to zero.
// R13: Programmer reloads the pointer with the ID base after code verify.
// R14: Programmer merges byte pairs for code words; config bytes compared singly.
// R15: EEPROM read: clear selects, load address, set read bit; byte lands in the EEPROM data register.
// R16: Shift-out command sends the table latch after the same turnaround.
// R17: Shift-out result carries the latched byte in its high byte.
// R18: Core-instruction payload executes as an internal instruction.
// R19: Erased code, ID and EEPROM bytes read as all ones.
// R20: Unimplemented configuration bits always read as zero.
// R21: Blank check by programmer excludes the two device identification bytes.
// R22: Only one party drives the data line; device only in its output phase.
`timescale 1ns/1ns
`include "spc_map.svh"
module spc_prog_port #(
    parameter int         CODE_BYTES  = `SPC_CODE_BYTES,
    parameter int         EE_BYTES    = `SPC_EE_BYTES,
    parameter int         FIFO_DEPTH  = `SPC_FIFO_DEPTH,
    parameter logic [7:0] DEV_ID_LO   = 8'h5a,  // Arbitrary identification value
    parameter logic [7:0] DEV_ID_HI   = 8'ha5   // Arbitrary identification value
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Programming pins
    input  wire logic        prog_serial_clock_i,
    input  wire logic        prog_serial_line_i,
    output logic             prog_serial_line_o,
    output logic             prog_serial_line_oe_o,
    // Status
    output logic             busy_o,
    output logic             cfg_reject_o,
    output logic             overrun_o,
    output logic [21:0]      table_ptr_o,
    output logic [7:0]       mem_control_reg_o
);
    localparam int          WW        = `SPC_WORD_BITS;
    localparam int          EAW       = $clog2(EE_BYTES);
    localparam logic [21:0] CODE_LAST = 22'(CODE_BYTES - 1);
    localparam logic [111:0] CFG_MASK = `SPC_CFG_MASK;

    // Synchronised pins
    logic clk_fall;
    logic line_s;

    spc_pin_sync u_sync (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ser_clk_i  (prog_serial_clock_i),
        .ser_line_i (prog_serial_line_i),
        .clk_fall_o (clk_fall),
        .line_o     (line_s)
    );

    // Command stream from shifter to executor
    spc_stream_if #(.W(WW)) sh_s ();
    spc_stream_if #(.W(WW)) ex_s ();

    spc_fifo #(.W(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .in_s  (sh_s),
        .out_s (ex_s)
    );

    // ---------------- Serial shifter ----------------
    spc_pkg::spc_shift_t sh_state_q, sh_state_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [3:0]  cmd_q, cmd_d;
    logic [15:0] pay_q, pay_d;
    logic [7:0]  out_q, out_d;
    logic        oe_q, oe_d;
    logic        push;
    logic        overrun_q;
    logic [7:0]  rd_byte_q;

    wire [3:0] cmd_full   = {line_s, cmd_q[3:1]};
    wire       is_read    = (cmd_full == spc_pkg::SPC_CMD_TABLE_READ_OP) ||
                            (cmd_full == spc_pkg::SPC_CMD_SHOUT);
    wire       last_cmd   = (cnt_q == 4'(`SPC_CMD_BITS - 1));
    wire       last_pay   = (cnt_q == 4'(`SPC_PAY_BITS - 1));
    wire       last_byte  = (cnt_q == 4'(`SPC_OPER_BITS - 1));

    assign sh_s.valid = push;
    assign sh_s.data  = (sh_state_q == spc_pkg::SPC_SH_CMD) ? {cmd_full, 16'h0000}
                                                            : {cmd_q, line_s, pay_q[15:1]};

    always_comb begin
        sh_state_d = sh_state_q;
        cnt_d      = cnt_q;
        cmd_d      = cmd_q;
        pay_d      = pay_q;
        out_d      = out_q;
        oe_d       = oe_q;
        push       = 1'b0;
        if (clk_fall) begin
            cnt_d = cnt_q + 4'h1;
            unique case (sh_state_q)
                spc_pkg::SPC_SH_CMD: begin
                    cmd_d = cmd_full;  // see R9
                    if (last_cmd) begin
                        cnt_d = 4'h0;
                        // Reads go to the executor now so the byte is ready
                        push       = is_read;
                        sh_state_d = is_read ? spc_pkg::SPC_SH_OPER : spc_pkg::SPC_SH_PAY;
                    end
                end
                spc_pkg::SPC_SH_PAY: begin
                    pay_d = {line_s, pay_q[15:1]};
                    if (last_pay) begin
                        cnt_d      = 4'h0;
                        push       = 1'b1;
                        sh_state_d = spc_pkg::SPC_SH_CMD;
                    end
                end
                spc_pkg::SPC_SH_OPER: begin
                    if (last_byte) begin
                        cnt_d      = 4'h0;
                        out_d      = rd_byte_q;   // see R16
                        oe_d       = 1'b1;        // see R10
                        sh_state_d = spc_pkg::SPC_SH_OUT;
                    end
                end
                spc_pkg::SPC_SH_OUT: begin
                    out_d = {1'b0, out_q[7:1]};   // see R9
                    if (last_byte) begin
                        cnt_d      = 4'h0;
                        oe_d       = 1'b0;        // see R22
                        sh_state_d = spc_pkg::SPC_SH_CMD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sh_state_q <= spc_pkg::SPC_SH_CMD;
            cnt_q      <= 4'h0;
            cmd_q      <= 4'h0;
            pay_q      <= 16'h0000;
            out_q      <= 8'h00;
            oe_q       <= 1'b0;
        end else begin
            sh_state_q <= sh_state_d;
            cnt_q      <= cnt_d;
            cmd_q      <= cmd_d;
            pay_q      <= pay_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overrun_q <= 1'b0;
        end else if (push && !sh_s.ready) begin
            overrun_q <= 1'b1;
        end
    end

    // LSB of shift register is the bit on the line
    assign prog_serial_line_o    = out_q[0];
    assign prog_serial_line_oe_o = oe_q;       // see R22
    assign overrun_o             = overrun_q;

    // ---------------- Executor ----------------
    logic [21:0] ptr_q, ptr_d;
    logic [7:0]  w_q, w_d;
    logic [7:0]  latch_q, latch_d;
    logic [7:0]  ctl_q, ctl_d;
    logic [7:0]  ee_lo_q, ee_lo_d;
    logic [7:0]  ee_hi_q, ee_hi_d;
    logic [7:0]  ee_data_q, ee_data_d;
    logic [7:0]  rd_byte_d;
    logic [15:0] busy_q, busy_d;
    logic        reject_q, reject_d;
    logic        cfg_we, ee_we;
    logic [7:0]  cfg_q [`SPC_CFG_COUNT];
    logic [7:0]  ee_q  [EE_BYTES];

    // Stalls the queue while a write is in progress
    assign ex_s.ready = (busy_q == 16'h0000);

    wire        fire     = ex_s.valid & ex_s.ready;
    wire [3:0]  x_cmd    = ex_s.data[19:16];
    wire [15:0] x_pay    = ex_s.data[15:0];
    wire [7:0]  x_f      = x_pay[7:0];
    wire [2:0]  x_bit    = x_pay[11:9];
    wire        op_movlw = (x_pay[15:8] == `SPC_OP_MOVLW);
    wire        op_movwf = (x_pay[15:8] == `SPC_OP_MOVWF);
    wire        op_bsf   = (x_pay[15:12] == `SPC_OP_BSF);
    wire        op_bcf   = (x_pay[15:12] == `SPC_OP_BCF);
    wire        op_movf  = (x_pay[15:10] == `SPC_OP_MOVF) && !x_pay[9];
    wire        sel_none = !ctl_q[`SPC_CTL_CODE_SEL] && !ctl_q[`SPC_CTL_CFG_SEL];
    wire        sel_cfg  = ctl_q[`SPC_CTL_CODE_SEL] && ctl_q[`SPC_CTL_CFG_SEL];
    wire [EAW-1:0] ee_idx = EAW'({ee_hi_q, ee_lo_q});

    // Table read decode across the whole 22-bit space
    wire        in_code  = ({10'h000, ptr_q} < 32'(CODE_BYTES));
    wire        in_id    = (ptr_q[21:3] == `SPC_ID_BASE >> 3);
    wire        in_cfg   = (ptr_q[21:4] == `SPC_CFG_BASE >> 4) && (ptr_q[3:0] <= `SPC_CFG_LAST);
    wire [7:0]  cfg_rd   = cfg_q[ptr_q[3:0]] & CFG_MASK[{ptr_q[3:0], 3'h0} +: 8];  // see R20
    wire [7:0]  mem_rd   = (in_code || in_id)          ? `SPC_ERASED :   // see R19
                           in_cfg                      ? cfg_rd :        // see R11
                           (ptr_q == `SPC_DEVID_LO)    ? DEV_ID_LO :
                           (ptr_q == `SPC_DEVID_HI)    ? DEV_ID_HI : `SPC_UNIMPL;
    wire [21:0] ptr_inc  = (ptr_q == CODE_LAST) ? 22'h000000 : ptr_q + 22'h000001;  // see R12

    // Configuration write target
    wire        cfg_lock = !cfg_q[`SPC_CFG_PROT_IDX][`SPC_CFG_PROT_BIT];
    wire [7:0]  cfg_wdat = ptr_q[0] ? x_pay[15:8] : x_pay[7:0];   // see R3
    wire [7:0]  sfr_val  = (x_f == `SPC_F_PTR_U)   ? {2'h0, ptr_q[21:16]} :
                           (x_f == `SPC_F_PTR_H)   ? ptr_q[15:8] :
                           (x_f == `SPC_F_PTR_L)   ? ptr_q[7:0] :
                           (x_f == `SPC_F_LATCH)   ? latch_q :
                           (x_f == `SPC_F_MEMCTL)  ? ctl_q :
                           (x_f == `SPC_F_EE_LO)   ? ee_lo_q :
                           (x_f == `SPC_F_EE_HI)   ? ee_hi_q :
                           (x_f == `SPC_F_EE_DATA) ? ee_data_q : 8'h00;

    always_comb begin
        ptr_d     = ptr_q;
        w_d       = w_q;
        latch_d   = latch_q;
        ctl_d     = ctl_q;
        ee_lo_d   = ee_lo_q;
        ee_hi_d   = ee_hi_q;
        ee_data_d = ee_data_q;
        rd_byte_d = rd_byte_q;
        busy_d    = busy_q;
        reject_d  = 1'b0;
        cfg_we    = 1'b0;
        ee_we     = 1'b0;
        if (busy_q != 16'h0000) begin
            busy_d = busy_q - 16'h0001;
            if (busy_q == 16'h0001) begin
                ctl_d[`SPC_CTL_WR] = 1'b0;
            end
        end
        if (fire) begin
            unique case (x_cmd)
                spc_pkg::SPC_CMD_CORE: begin   // see R18
                    if (op_movlw) begin
                        w_d = x_f;
                    end else if (op_movwf) begin
                        unique case (x_f)
                            `SPC_F_PTR_U:   ptr_d[21:16] = w_q[5:0];
                            `SPC_F_PTR_H:   ptr_d[15:8]  = w_q;
                            `SPC_F_PTR_L:   ptr_d[7:0]   = w_q;
                            `SPC_F_LATCH:   latch_d      = w_q;
                            `SPC_F_MEMCTL:  ctl_d        = w_q & 8'hc4;
                            `SPC_F_EE_LO:   ee_lo_d      = w_q;
                            `SPC_F_EE_HI:   ee_hi_d      = w_q;
                            `SPC_F_EE_DATA: ee_data_d    = w_q;
                            default:        w_d          = w_q;
                        endcase
                    end else if ((op_bsf || op_bcf) && x_f == `SPC_F_MEMCTL) begin
                        ctl_d[x_bit] = op_bsf;
                        if (op_bsf && x_bit == 3'(`SPC_CTL_RD)) begin
                            ctl_d[`SPC_CTL_RD] = 1'b0;
                            if (sel_none) begin
                                ee_data_d = ee_q[ee_idx];   // see R15
                            end
                        end
                        if (op_bsf && x_bit == 3'(`SPC_CTL_WR)) begin
                            if (sel_none && ctl_q[`SPC_CTL_WREN]) begin
                                ee_we  = 1'b1;
                                busy_d = 16'(`SPC_EE_PROG_CYC);
                            end else begin
                                ctl_d[`SPC_CTL_WR] = 1'b0;
                            end
                        end
                    end else if (op_movf) begin
                        w_d = sfr_val;
                    end
                end
                spc_pkg::SPC_CMD_TABLE_READ_OP: begin
                    rd_byte_d = mem_rd;    // see R8
                    latch_d   = mem_rd;
                    ptr_d     = ptr_inc;   // see R8
                end
                spc_pkg::SPC_CMD_SHOUT: rd_byte_d = latch_q;   // see R17
                spc_pkg::SPC_CMD_CFGWR: begin
                    if (sel_cfg && in_cfg) begin
                        if (cfg_lock) begin
                            reject_d = 1'b1;   // see R7
                        end else begin
                            cfg_we = 1'b1;     // see R2
                            busy_d = 16'(`SPC_CFG_PROG_CYC);   // see R6
                        end
                    end
                end
                default: rd_byte_d = rd_byte_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_q     <= 22'h000000;
            w_q       <= 8'h00;
            latch_q   <= 8'h00;
            ctl_q     <= 8'h00;
            ee_lo_q   <= 8'h00;
            ee_hi_q   <= 8'h00;
            ee_data_q <= 8'h00;
            rd_byte_q <= 8'h00;
            busy_q    <= 16'h0000;
            reject_q  <= 1'b0;
        end else begin
            ptr_q     <= ptr_d;
            w_q       <= w_d;
            latch_q   <= latch_d;
            ctl_q     <= ctl_d;
            ee_lo_q   <= ee_lo_d;
            ee_hi_q   <= ee_hi_d;
            ee_data_q <= ee_data_d;
            rd_byte_q <= rd_byte_d;
            busy_q    <= busy_d;
            reject_q  <= reject_d;
        end
    end

    // Configuration bytes, erased state holds every implemented bit at one
    genvar gi;
    generate
        for (gi = 0; gi < `SPC_CFG_COUNT; gi++) begin : g_cfg
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    cfg_q[gi] <= CFG_MASK[gi*8 +: 8];
                end else if (cfg_we && ptr_q[3:0] == 4'(gi)) begin
                    cfg_q[gi] <= cfg_wdat & CFG_MASK[gi*8 +: 8];   // see R20
                end
            end
        end
    endgenerate

    // Data EEPROM, erased at reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < EE_BYTES; i++) begin
                ee_q[i] <= `SPC_ERASED;
            end
        end else if (ee_we) begin
            ee_q[ee_idx] <= ee_data_q;
        end
    end

    assign busy_o            = (busy_q != 16'h0000);
    assign cfg_reject_o      = reject_q;
    assign table_ptr_o       = ptr_q;
    assign mem_control_reg_o = ctl_q;
endmodule

// ==== sim/spc_prog_port_chk.sv ====
`timescale 1ns/1ns
module spc_prog_port_chk (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Watched ports
    input  wire logic        prog_serial_clock_i,
    input  wire logic        prog_serial_line_o,
    input  wire logic        prog_serial_line_oe_o,
    input  wire logic        busy_o,
    input  wire logic        cfg_reject_o,
    input  wire logic [21:0] table_ptr_o,
    input  wire logic [7:0]  mem_control_reg_o
);
    logic       pin_q;
    logic [3:0] falls_q;
    logic [7:0] since_q;
    logic [9:0] busy_q;
    wire logic  fall = pin_q && !prog_serial_clock_i;

    // Falls during the output phase, cycles since the last fall, busy length
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q   <= 1'b0;
            falls_q <= 4'h0;
            since_q <= 8'hff;
            busy_q  <= 10'h000;
        end else begin
            pin_q   <= prog_serial_clock_i;
            falls_q <= !prog_serial_line_oe_o ? 4'h0 : falls_q + 4'(fall);
            since_q <= fall ? 8'h00 : since_q + 8'(since_q != 8'hff);
            busy_q  <= busy_o ? busy_q + 10'h001 : 10'h000;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    out_count_a: assert property ($fell(prog_serial_line_oe_o) |-> falls_q == 4'h8)
        else $error("output phase did not span eight clock falls");
    bit_timing_a: assert property (prog_serial_line_oe_o && $past(prog_serial_line_oe_o)
        && $changed(prog_serial_line_o) |-> since_q inside {[1:5]})
        else $error("output bit changed away from a clock fall");
    oe_turn_a: assert property ($rose(prog_serial_line_oe_o) |-> since_q inside {[1:5]})
        else $error("line turned to output away from a clock fall");
    busy_len_a: assert property ($fell(busy_o) |-> busy_q inside {[99:101], [399:401]})
        else $error("write busy time wrong");
    reset_vals_a: assert property ($fell(rst_i) |-> table_ptr_o == 22'h000000
        && mem_control_reg_o == 8'h00 && !prog_serial_line_oe_o && !busy_o)
        else $error("outputs not cleared by reset");
    reject_pulse_a: assert property (cfg_reject_o |=> !cfg_reject_o)
        else $error("refusal flag longer than one cycle");
    reject_idle_a: assert property (cfg_reject_o |-> !busy_o [*3])
        else $error("refused write started programming");
    ptr_hold_a: assert property ($rose(busy_o) && mem_control_reg_o[6]
        |=> $stable(table_ptr_o) [*8])
        else $error("pointer moved on configuration write");
endmodule

bind spc_prog_port spc_prog_port_chk u_chk (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .prog_serial_clock_i   (prog_serial_clock_i),
    .prog_serial_line_o    (prog_serial_line_o),
    .prog_serial_line_oe_o (prog_serial_line_oe_o),
    .busy_o                (busy_o),
    .cfg_reject_o          (cfg_reject_o),
    .table_ptr_o           (table_ptr_o),
    .mem_control_reg_o     (mem_control_reg_o)
);

// ==== sim/spc_programmer.sv ====
`timescale 1ns/1ns
module spc_programmer (
    // Pins
    output logic      ser_clk_o,
    output logic      ser_dat_o,
    input  wire logic ser_line_i
);
    logic [19:0] w;

    initial begin
        ser_clk_o = 1'b0;
        ser_dat_o = 1'b0;
    end

    // One frame, 80 ns link period; clock idles low between frames
    task automatic frame(input logic [3:0] c, input logic [15:0] p, input bit lng,
                         output logic [7:0] r);
        bit isr;
        isr = (c == 4'h9) || (c == 4'h2);
        w   = {p, c};
        r   = 8'h00;
        for (int i = 0; i < 20; i++) begin
            ser_clk_o = 1'b1;
            if (!(isr && i >= 12))
                ser_dat_o = w[i];
            #40;
            if (lng && i == 3)
                #1000;
            if (isr && i >= 12)
                r[i-12] = ser_line_i;
            ser_clk_o = 1'b0;
            #40;
            if (isr && i == 11) begin
                ser_dat_o = ~ser_dat_o;
                #160;
            end
        end
        if (lng)
            #400;
    endtask
endmodule

// ==== sim/tb_serial_prog_config_write_and_readback.sv ====
`timescale 1ns/1ns
`include "spc_map.svh"
module tb_serial_prog_config_write_and_readback;
    localparam logic [7:0]   ID_LO = 8'h3c;  // Arbitrary identification value
    localparam logic [111:0] CM    = `SPC_CFG_MASK;
    logic        clk_i;
    logic        rst_i;
    logic        pclk, pdat, dline, doe, busy, rej, ovr;
    logic [21:0] ptr;
    logic [7:0]  ctl, rd;
    int          mismatches = 0;
    int          checked = 0;
    int          rejects = 0;
    wire logic   line = doe ? dline : pdat;
    logic [21:0] ra [6] = '{22'h0, 22'h00ffff, 22'h200000, 22'h300001, 22'h300004, 22'h3ffffe};
    logic [7:0]  re [6] = '{8'hff, 8'hff, 8'hff, CM[15:8], CM[39:32], ID_LO};
    logic [21:0] rp [6] = '{22'h1, 22'h0, 22'h200001, 22'h300002, 22'h300005, 22'h3fffff};
    logic [15:0] ee [18] = '{16'h9ea6, 16'h9ca6, 16'h0e07, 16'h6ea9, 16'h0e00,
                             16'h6eaa, 16'h80a6, 16'h50a8, 16'h6ef5, 16'h0e33, 16'h6ea8,
                             16'h84a6, 16'h82a6, 16'h0e00, 16'h6ea8, 16'h80a6, 16'h50a8,
                             16'h6ef5};

    spc_prog_port #(.DEV_ID_LO(ID_LO)) u_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .prog_serial_clock_i   (pclk),
        .prog_serial_line_i    (line),
        .prog_serial_line_o    (dline),
        .prog_serial_line_oe_o (doe),
        .busy_o                (busy),
        .cfg_reject_o          (rej),
        .overrun_o             (ovr),
        .table_ptr_o           (ptr),
        .mem_control_reg_o     (ctl)
    );
    spc_programmer u_prg (.ser_clk_o(pclk), .ser_dat_o(pdat), .ser_line_i(line));

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic core(input logic [15:0] p);
        u_prg.frame(4'h0, p, 1'b0, rd);
    endtask
    task automatic setp(input logic [21:0] a);
        core({8'h0e, 2'b00, a[21:16]});
        core(16'h6ef8);
        core({8'h0e, a[15:8]});
        core(16'h6ef7);
        core({8'h0e, a[7:0]});
        core(16'h6ef6);
    endtask
    task automatic tread(input logic [21:0] a, input logic [7:0] e);
        setp(a);
        u_prg.frame(4'h9, 16'h0000, 1'b0, rd);
        chk(rd, e);
    endtask
    task automatic cwr(input logic [21:0] a, input logic [15:0] p);
        setp(a);
        u_prg.frame(4'hf, p, 1'b0, rd);
        u_prg.frame(4'h0, 16'h0000, 1'b1, rd);
        chk(ptr, a);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(negedge clk_i) if (rej === 1'b1) rejects++;
    initial begin
        #600000;
        mismatches++;
        wrap_up();
    end

    initial begin
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (5) @(posedge clk_i);
        #1;
        for (int i = 0; i < 6; i++) begin
            tread(ra[i], re[i]);
            chk(ptr, rp[i]);
        end
        // Reset in mid-run
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 rst_i = 1'b0;
        chk({2'h0, ctl, ptr}, 32'h0);
        repeat (5) @(posedge clk_i);
        #1;
        core(16'h8ea6);
        core(16'h8ca6);
        chk(ctl, 8'hc0);
        cwr(22'h300000, 16'hff05);
        tread(22'h300000, 8'h05 & CM[7:0]);
        cwr(22'h300001, 16'h41ff);
        tread(22'h300001, 8'h41 & CM[15:8]);
        cwr(22'h30000b, 16'h00ff);
        cwr(22'h300000, 16'h00ff);
        chk(rejects, 1);
        tread(22'h300000, 8'h05 & CM[7:0]);
        core(16'h0e5a);
        core(16'h6ef5);
        u_prg.frame(4'h2, 16'h0000, 1'b0, rd);
        chk(rd, 8'h5a);
        for (int i = 0; i < 18; i++) begin
            core(ee[i]);
            if (i == 8 || i == 17) begin
                u_prg.frame(4'h2, 16'h0000, 1'b0, rd);
                chk(rd, (i == 8) ? 8'hff : 8'h33);
            end
        end
        chk(ovr, 1'b0);
        wrap_up();
    end
endmodule
